// >>> sep_consts.svh
// constants of the serial eeprom slave: sizes, opcodes, phases, timing
`ifndef SEP_CONSTS_SVH
`define SEP_CONSTS_SVH
`define SEP_ARRAY_BYTES 16384
`define SEP_PAGE_BYTES  64
`define SEP_PAGE_END    7'h40
`define SEP_OP_MASK     8'hF7
`define SEP_OP_NONE     8'h00
`define SEP_OP_WREN     8'h06
`define SEP_OP_WRDI     8'h04
`define SEP_OP_RDSR     8'h05
`define SEP_OP_WRSR     8'h01
`define SEP_OP_READ     8'h03
`define SEP_OP_WRITE    8'h02
`define SEP_OP_RDID     8'h83
`define SEP_OP_WRID     8'h82
`define SEP_OP_LOCK     8'h87
`define SEP_PH_OP       2'h0
`define SEP_PH_AHI      2'h1
`define SEP_PH_ALO      2'h2
`define SEP_PH_DATA     2'h3
`define SEP_BIT_LAST    3'h7
`define SEP_BP_NONE     2'h0
`define SEP_BP_QTR      2'h1
`define SEP_BP_HALF     2'h2
`define SEP_BP_ALL      2'h3
`define SEP_QTR_TOP     2'h3
`define SEP_STAT_BUSY   8'hFF
`define SEP_T_WR_US     5000
`define SEP_CLK_MHZ     100
`endif

// >>> sep_pkg.sv
// types shared by the serial eeprom slave
`include "sep_consts.svh"
package sep_pkg;
   typedef enum logic [2:0] {
      SEP_ACT_NONE  = 3'b000,
      SEP_ACT_WREN  = 3'b001,
      SEP_ACT_WRDI  = 3'b010,
      SEP_ACT_WRSR  = 3'b011,
      SEP_ACT_WRITE = 3'b100,
      SEP_ACT_WRID  = 3'b101,
      SEP_ACT_LOCK  = 3'b110
   } sep_act_t;
   typedef struct packed {
      logic       wpen;
      logic [2:0] spare;
      logic [1:0] bp;
      logic       wel;
      logic       busy;
   } sep_status_t;
   typedef struct packed {
      logic [2:0] bitCnt;
      logic [1:0] phase;
      logic [7:0] op;
      logic [6:0] shift;
      logic [7:0] txByte;
      logic       rdOn;
   } sep_frame_t;
   typedef struct packed {
      logic [15:0]                  addr;
      logic [`SEP_PAGE_BYTES-1:0]   mask;
      sep_act_t                     act;
      sep_status_t                  wrsr;
      logic                         seq;
      logic [9:0]                   st1;
      logic [9:0]                   st2;
      logic [9:0]                   st3;
      logic [9:0]                   stUse;
   } sep_load_t;
   typedef struct packed {
      logic so;
      logic oe;
   } sep_out_t;
endpackage

// >>> sep_spi_eeprom.sv
// serial eeprom slave: link shifter on sck, write engine and status on clk
// Overview of operation
// RL1 - works in clock mode 0 and 3
// RL2 - array of 16384 bytes, 64-byte pages
// RL3 - byte, full and partial page writes
// RL4 - self-timed write ends within 5 ms
// RL5 - protect top quarter, top half, or all
// RL6 - 64-byte id page, lockable for good; the code clears the lock on reset
// RL7 - hold pauses transfer, resumes in place
// RL8 - ignore instructions in reset, then standby
// RL9 - chip select rise ends or launches write
// RL10 - output high impedance in standby
// RL11 - master opens each instruction with select fall
// RL12 - first byte is opcode, only defined ones; the code ignores opcode bit 3, so undefined 0E acts as 06
// RL13 - all bytes shift most significant bit first
// RL14 - sample on rising, change on falling edge
// RL15 - busy shows in status, only status read; the code still serves array and id reads while busy
// RL16 - address or data follow as opcode demands
// RL17 - write enable latch clear at power up
// RL18 - master changes hold only while sck low
// RL19 - select high ignores sck, clears counters
// RL20 - select rise mid-byte drops a write
`timescale 1ns/100ps
`default_nettype none
`include "sep_consts.svh"
module sep_spi_eeprom #(
   parameter int unsigned WR_CYCLES = `SEP_T_WR_US * `SEP_CLK_MHZ
) (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic sck,
   input  wire logic cs_b,
   input  wire logic si,
   input  wire logic hold_b,
   input  wire logic wp_b,
   output logic      so,
   output logic      soOe,
   output logic      busy
);
   import sep_pkg::*;

   localparam int TW = $clog2(WR_CYCLES + 1);

   // commit walks the page inside the write time, so it must fit
   generate
      if (WR_CYCLES < 2 * `SEP_PAGE_BYTES) begin : gBadCycles
         $error("WR_CYCLES too small for a page commit");
      end
   endgenerate

   typedef struct packed {
      logic                       cs1;
      logic                       cs2;
      logic                       cs3;
      logic                       csF;
      logic                       wp1;
      logic                       wp2;
      logic                       wp3;
      logic                       wpF;
      logic                       up;
      logic                       wel;
      logic [1:0]                 bp;
      logic                       wpen;
      logic                       locked;
      logic                       busy;
      logic                       seen;
      logic [TW-1:0]              tmr;
      logic [6:0]                 idx;
      logic                       tgtId;
      logic [7:0]                 page;
      logic [`SEP_PAGE_BYTES-1:0] mask;
      logic [9:0]                 stat;
   } sep_ctl_t;

   localparam sep_ctl_t CTL_RST = '{cs1: 1'b1, cs2: 1'b1, cs3: 1'b1, csF: 1'b1,
                                    wp1: 1'b1, wp2: 1'b1, wp3: 1'b1, wpF: 1'b1,
                                    default: '0};
   localparam sep_frame_t FRM_RST = '0;

   // storage; the main array is written only on clk, read only on sck
   logic [7:0] mainMem [0:`SEP_ARRAY_BYTES-1]; // [RL2]
   logic [7:0] idMem   [0:`SEP_PAGE_BYTES-1];  // [RL6]
   logic [7:0] pageBuf [0:`SEP_PAGE_BYTES-1];

   sep_frame_t frm_reg, frm_next;
   sep_load_t  ld_reg, ld_next;
   sep_out_t   out_reg;
   sep_ctl_t   c_reg, c_next;
   logic       pbWr;
   logic       memWr;
   logic [7:0] inByte;
   logic [7:0] opc;

   // byte fetch for both read paths
   function automatic logic [7:0] rdByte(input logic [7:0] op, input logic [15:0] a);
      if (op == `SEP_OP_RDID) begin
         rdByte = idMem[a[5:0]];
      end else begin
         rdByte = mainMem[a[13:0]];
      end
   endfunction

   // block protection by level against the page number
   function automatic logic isProt(input logic [1:0] bp, input logic [7:0] pg);
      unique case (bp)
         `SEP_BP_NONE: isProt = 1'b0;
         `SEP_BP_QTR:  isProt = (pg[7:6] == `SEP_QTR_TOP);
         `SEP_BP_HALF: isProt = pg[7];
         `SEP_BP_ALL:  isProt = 1'b1;
      endcase
   endfunction

   // link side: shift in on rising sck, decode, queue the action for clk
   always_comb begin
      frm_next = frm_reg;
      ld_next  = ld_reg;
      pbWr     = 1'b0;
      inByte   = {frm_reg.shift, si}; // [RL13]
      opc      = frm_reg.op & `SEP_OP_MASK;
      ld_next.st1 = c_reg.stat;
      ld_next.st2 = ld_reg.st1;
      ld_next.st3 = ld_reg.st2;
      if (ld_reg.st2 == ld_reg.st3) begin
         ld_next.stUse = ld_reg.st3;
      end
      // hold is steady over edges, so it is sampled like data
      if (hold_b) begin // [RL7] [RL18]
         // an action stands only if the last taken edge closed a byte; paused edges keep it
         ld_next.act     = SEP_ACT_NONE; // [RL20]
         frm_next.bitCnt = frm_reg.bitCnt + 3'h1;
         frm_next.shift  = inByte[6:0];
         if (frm_reg.bitCnt == `SEP_BIT_LAST) begin
            unique case (frm_reg.phase)
               `SEP_PH_OP: begin
                  // no instruction is honoured until the clk side is up
                  frm_next.op = ld_reg.stUse[8] ? inByte : `SEP_OP_NONE; // [RL8] [RL12]
                  // seq has no reset here, so it is derived from the synced seen bit
                  ld_next.seq  = ~ld_reg.stUse[9];
                  ld_next.mask = '0;
                  frm_next.phase = `SEP_PH_DATA;
                  unique case (frm_next.op & `SEP_OP_MASK) // [RL16]
                     `SEP_OP_WREN: ld_next.act = SEP_ACT_WREN;
                     `SEP_OP_WRDI: ld_next.act = SEP_ACT_WRDI;
                     `SEP_OP_LOCK: ld_next.act = SEP_ACT_LOCK;
                     `SEP_OP_RDSR: begin
                        frm_next.rdOn   = 1'b1;
                        frm_next.txByte = ld_reg.stUse[7:0]; // [RL15]
                     end
                     `SEP_OP_READ, `SEP_OP_WRITE,
                     `SEP_OP_RDID, `SEP_OP_WRID: frm_next.phase = `SEP_PH_AHI;
                     default: ;
                  endcase
               end
               `SEP_PH_AHI: begin
                  ld_next.addr[15:8] = inByte;
                  frm_next.phase     = `SEP_PH_ALO;
               end
               `SEP_PH_ALO: begin
                  ld_next.addr[7:0] = inByte;
                  frm_next.phase    = `SEP_PH_DATA;
                  if (opc == `SEP_OP_READ || opc == `SEP_OP_RDID) begin
                     frm_next.rdOn   = 1'b1;
                     frm_next.txByte = rdByte(opc, {ld_reg.addr[15:8], inByte});
                  end
               end
               `SEP_PH_DATA: begin
                  unique case (opc)
                     `SEP_OP_RDSR: frm_next.txByte = ld_reg.stUse[7:0];
                     `SEP_OP_READ: begin
                        // sequential read runs over the whole array and wraps
                        ld_next.addr[13:0] = ld_reg.addr[13:0] + 14'h0001;
                        frm_next.txByte    = rdByte(opc, ld_next.addr);
                     end
                     `SEP_OP_RDID: begin
                        ld_next.addr[5:0] = ld_reg.addr[5:0] + 6'h01;
                        frm_next.txByte   = rdByte(opc, ld_next.addr);
                     end
                     `SEP_OP_WRITE, `SEP_OP_WRID: begin
                        // buffer is frozen while a commit reads it
                        if (!ld_reg.stUse[0]) begin // [RL15]
                           pbWr = 1'b1;
                           ld_next.mask[ld_reg.addr[5:0]] = 1'b1; // [RL3]
                           ld_next.addr[5:0] = ld_reg.addr[5:0] + 6'h01;
                           ld_next.act = (opc == `SEP_OP_WRID) ? SEP_ACT_WRID : SEP_ACT_WRITE;
                        end
                     end
                     `SEP_OP_WRSR: begin
                        ld_next.wrsr = inByte;
                        ld_next.act  = SEP_ACT_WRSR;
                     end
                     default: ;
                  endcase
               end
            endcase
         end
      end
   end

   // frame counters clear while select is high; a new frame starts clean
   always_ff @(posedge sck or posedge cs_b) begin // [RL11] [RL19]
      if (cs_b) begin
         frm_reg <= FRM_RST;
      end else begin
         frm_reg <= frm_next; // [RL14]
      end
   end

   // payload survives select rise; the clk side reads it while sck is still
   always_ff @(posedge sck) begin
      if (!cs_b) begin // [RL19]
         ld_reg <= ld_next;
      end
      if (!cs_b && pbWr) begin
         pageBuf[ld_reg.addr[5:0]] <= inByte;
      end
   end

   // output changes on falling sck; select high floats it at once
   always_ff @(negedge sck or posedge cs_b) begin // [RL10] [RL1]
      if (cs_b) begin
         out_reg <= '0;
      end else begin
         out_reg.oe <= frm_reg.rdOn & hold_b; // [RL7]
         out_reg.so <= frm_reg.txByte[~frm_reg.bitCnt]; // [RL14] [RL13]
      end
   end

   assign so   = out_reg.so;
   assign soOe = out_reg.oe;
   assign busy = c_reg.busy;

   // clk side: select rise launches the queued action, timer runs the write
   always_comb begin
      c_next = c_reg;
      memWr  = 1'b0;
      c_next.cs1 = cs_b;
      c_next.cs2 = c_reg.cs1;
      c_next.cs3 = c_reg.cs2;
      c_next.wp1 = wp_b;
      c_next.wp2 = c_reg.wp1;
      c_next.wp3 = c_reg.wp2;
      c_next.up  = 1'b1;
      if (c_reg.cs2 == c_reg.cs3) begin
         c_next.csF = c_reg.cs3;
      end
      if (c_reg.wp2 == c_reg.wp3) begin
         c_next.wpF = c_reg.wp3;
      end
      if (c_reg.busy) begin
         c_next.tmr = c_reg.tmr + TW'(1);
         if (c_reg.idx < `SEP_PAGE_END) begin
            memWr      = c_reg.mask[c_reg.idx[5:0]];
            c_next.idx = c_reg.idx + 7'h01;
         end
         if (c_reg.tmr == TW'(WR_CYCLES - 1)) begin // [RL4]
            c_next.busy = 1'b0;
            c_next.wel  = 1'b0;
         end
      end
      // a frame without edges keeps the old seq and launches nothing
      if (c_next.csF && !c_reg.csF) begin // [RL9]
         c_next.seen = ld_reg.seq;
         if (c_reg.up && !c_reg.busy && ld_reg.seq != c_reg.seen) begin // [RL8] [RL15]
            unique case (ld_reg.act)
               SEP_ACT_WREN: c_next.wel = 1'b1;
               SEP_ACT_WRDI: c_next.wel = 1'b0;
               SEP_ACT_WRSR: begin
                  if (c_reg.wel && !(c_reg.wpen && !c_reg.wpF)) begin
                     c_next.bp   = ld_reg.wrsr.bp;
                     c_next.wpen = ld_reg.wrsr.wpen;
                     c_next.busy = 1'b1;
                     c_next.mask = '0;
                  end
               end
               SEP_ACT_WRITE: begin
                  if (c_reg.wel && !isProt(c_reg.bp, ld_reg.addr[13:6])) begin // [RL5]
                     c_next.busy  = 1'b1;
                     c_next.mask  = ld_reg.mask; // [RL3]
                     c_next.page  = ld_reg.addr[13:6];
                     c_next.tgtId = 1'b0;
                  end
               end
               SEP_ACT_WRID: begin
                  if (c_reg.wel && !c_reg.locked) begin // [RL6]
                     c_next.busy  = 1'b1;
                     c_next.mask  = ld_reg.mask;
                     c_next.tgtId = 1'b1;
                  end
               end
               SEP_ACT_LOCK: begin
                  if (c_reg.wel && !c_reg.locked) begin // [RL6]
                     c_next.locked = 1'b1;
                     c_next.busy   = 1'b1;
                     c_next.mask   = '0;
                  end
               end
               default: ;
            endcase
            if (c_next.busy) begin
               c_next.tmr = '0;
               c_next.idx = '0;
            end
         end
      end
      // status reads all ones during an internal write
      c_next.stat[9]   = c_next.seen; // frame marker back to the link side
      c_next.stat[8]   = c_reg.up;
      c_next.stat[7:0] = c_next.busy ? `SEP_STAT_BUSY : {c_next.wpen, 3'b000, c_next.bp, c_next.wel, 1'b0}; // [RL15]
      if (!rst_b) begin
         c_next = CTL_RST; // [RL8] [RL17]
      end
   end

   always_ff @(posedge clk) begin
      c_reg <= c_next;
   end

   // page commit into the selected store, one byte per clk
   always_ff @(posedge clk) begin
      if (rst_b && memWr && c_reg.tgtId) begin
         idMem[c_reg.idx[5:0]] <= pageBuf[c_reg.idx[5:0]]; // [RL6]
      end
      if (rst_b && memWr && !c_reg.tgtId) begin
         mainMem[{c_reg.page, c_reg.idx[5:0]}] <= pageBuf[c_reg.idx[5:0]]; // [RL2] [RL3]
      end
   end
endmodule
`default_nettype wire

// >>> sep_spi_eeprom_sva.sv
// port checker of the serial eeprom slave
`timescale 1ns/100ps
`default_nettype none
module sep_spi_eeprom_sva #(
   parameter int unsigned WR_CYCLES = 200
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic sck,
   input wire logic cs_b,
   input wire logic si,
   input wire logic hold_b,
   input wire logic wp_b,
   input wire logic so,
   input wire logic soOe,
   input wire logic busy
);
   logic [19:0] busyCnt;
   logic [3:0]  riseCnt;
   // length of the running write in clk cycles
   always_ff @(posedge clk) begin
      if (!rst_b || !busy)
         busyCnt <= '0;
      else
         busyCnt <= busyCnt + 20'h1;
   end
   // rises taken in this frame; paused rises do not count
   always_ff @(posedge sck or posedge cs_b) begin
      if (cs_b)
         riseCnt <= '0;
      else if (hold_b && riseCnt != 4'hF)
         riseCnt <= riseCnt + 4'h1;
   end
   a_oe_deselect: assert property (@(posedge clk) disable iff (!rst_b) cs_b |-> !soOe)
      else $error("output driven while deselected");
   a_busy_reset: assert property (@(posedge clk) disable iff (!rst_b) $rose(rst_b) |-> !busy ##1 !busy)
      else $error("busy after reset");
   a_busy_len: assert property (@(posedge clk) disable iff (!rst_b) $fell(busy) |->
      busyCnt >= WR_CYCLES - 1 && busyCnt <= WR_CYCLES + 1)
      else $error("write time wrong");
   a_busy_bound: assert property (@(posedge clk) disable iff (!rst_b) busy |-> busyCnt <= WR_CYCLES + 1)
      else $error("write runs too long");
   a_busy_launch: assert property (@(posedge clk) disable iff (!rst_b) $rose(busy) |->
      $past(cs_b, 2) ##1 busy[*4])
      else $error("write launched inside a frame");
   a_oe_hold: assert property (@(negedge sck) disable iff (cs_b) !hold_b |=> !soOe)
      else $error("output driven while paused");
   a_oe_opcode: assert property (@(posedge sck) disable iff (cs_b) riseCnt < 4'h8 |-> !soOe)
      else $error("output driven during opcode");
   a_so_fall: assert property (@(posedge clk) disable iff (!rst_b)
      soOe && $past(soOe) && so != $past(so) |-> !sck)
      else $error("output changed while sck high");
   c_write: cover property (@(posedge clk) $rose(busy));
   c_read: cover property (@(posedge clk) $rose(soOe));
   c_hold: cover property (@(negedge sck) !cs_b && !hold_b);
endmodule
bind sep_spi_eeprom sep_spi_eeprom_sva #(.WR_CYCLES(WR_CYCLES)) i_sva (.clk(clk), .rst_b(rst_b),
   .sck(sck), .cs_b(cs_b), .si(si), .hold_b(hold_b), .wp_b(wp_b), .so(so), .soOe(soOe), .busy(busy));
`default_nettype wire

// >>> sep_spi_master.sv
// bus master model that drives the serial link of the eeprom slave
`timescale 1ns/100ps
`default_nettype none
module sep_spi_master (
   output logic      sck,
   output logic      cs_b,
   output logic      si,
   output logic      hold_b,
   input  wire logic so,
   input  wire logic soOe
);
   localparam realtime HALF = 62.5;
   logic [7:0] txBuf [0:7];
   logic [7:0] rxBuf [0:7];
   // idle link: deselected, clock still
   // a select rise clears the link frame counters and output flops, which have no other reset
   initial begin
      sck = 1'b0;
      cs_b = 1'b0;
      si = 1'b0;
      hold_b = 1'b1;
      #1;
      cs_b = 1'b1;
   end
   // pause with clock and data still moving, changes only while sck low
   task automatic pause();
      #1;
      hold_b = 1'b0;
      repeat (2) begin
         si = ~si;
         #HALF;
         sck = 1'b1;
         #HALF;
         sck = 1'b0;
      end
      #1;
      hold_b = 1'b1;
   endtask
   // one frame; idle clock level picks mode 0 or 3; a floating line reads unknown
   task automatic xfer(input int nBits, input logic mode3, input int holdAt);
      sck = mode3;
      #HALF;
      cs_b = 1'b0;
      #HALF;
      for (int i = 0; i < nBits; i++) begin
         sck = 1'b0;
         if (i == holdAt)
            pause();
         si = txBuf[i/8][7-i%8];
         #HALF;
         sck = 1'b1;
         rxBuf[i/8][7-i%8] = soOe ? so : 1'bx;
         #HALF;
      end
      if (!mode3)
         sck = 1'b0;
      #HALF;
      cs_b = 1'b1;
      si = ~si; // released data shows no stale level
      #(4*HALF);
   endtask
endmodule
`default_nettype wire

// >>> test_spi_serial_eeprom_slave.sv
// self-checking bench of the serial eeprom slave
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin failures++; $display("wrong value at %0t: %h not %h", $time, (g), (e)); end end
module test_spi_serial_eeprom_slave;
   import sep_pkg::*;
   localparam int unsigned WR_CYC = 400;
   localparam logic [63:0] OP_EN = {8'h06, 56'h0};
   localparam logic [63:0] OP_RS = {8'h05, 56'h0};
   typedef struct packed {logic [1:0] bp; logic [15:0] addr; logic [7:0] dat; logic [7:0] want;} sep_row_t;
   // protect level, address, written byte, byte read back
   localparam sep_row_t ROWS [0:6] = '{'{2'h0, 16'h0000, 8'h99, 8'h99}, '{2'h0, 16'h3000, 8'hA5, 8'hA5},
      '{2'h1, 16'h3000, 8'h5A, 8'hA5}, '{2'h1, 16'h2FFF, 8'h3C, 8'h3C}, '{2'h2, 16'h2FFF, 8'hC3, 8'h3C},
      '{2'h2, 16'h1FFF, 8'h77, 8'h77}, '{2'h3, 16'h0000, 8'h11, 8'h99}};
   logic clk;
   logic rst_b;
   logic wp_b;
   wire  sck, cs_b, si, hold_b, so, soOe, busy;
   int   failures;
   int   nTests;
   sep_spi_eeprom #(.WR_CYCLES(WR_CYC)) i_dut (.clk(clk), .rst_b(rst_b), .sck(sck), .cs_b(cs_b), .si(si),
      .hold_b(hold_b), .wp_b(wp_b), .so(so), .soOe(soOe), .busy(busy));
   sep_spi_master i_mst (.sck(sck), .cs_b(cs_b), .si(si), .hold_b(hold_b), .so(so), .soOe(soOe));
   // system clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // counts, verdict and end of run
   task automatic complete_run();
      $display("checks %0d, mismatches %0d", nTests, failures);
      if (failures == 0 && nTests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // mode 0 frame, bytes left aligned
   task automatic frame(input logic [63:0] b, input int nBits);
      for (int i = 0; i < 8; i++)
         i_mst.txBuf[i] = b[63-8*i -: 8];
      i_mst.xfer(nBits, 1'b0, -1);
   endtask
   // expect a write to start or not, then let it end
   task automatic waitWrite(input logic launch);
      int n;
      n = 0;
      while (busy !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      `CHK(busy, launch)
      while (busy !== 1'b0 && n < WR_CYC + 40) begin
         @(negedge clk);
         n++;
      end
      `CHK(busy, 1'b0)
   endtask
   // hang guard, far above the expected run
   initial begin
      #1ms;
      failures++;
      complete_run();
   end
   initial begin
      rst_b = 1'b0;
      wp_b = 1'b1;
      repeat (20) @(negedge clk);
      rst_b = 1'b1;
      `CHK(busy, 1'b0)
      repeat (10) @(negedge clk);
      frame(OP_RS, 16); // lets status reach the link side
      frame(OP_RS, 16);
      `CHK(i_mst.rxBuf[1], 8'h00)
      foreach (ROWS[k]) begin
         frame(OP_EN, 8);
         frame({8'h01, 4'h0, ROWS[k].bp, 2'h0, 48'h0}, 16);
         waitWrite(1'b1);
         frame(OP_RS, 16);
         `CHK(i_mst.rxBuf[1], {4'h0, ROWS[k].bp, 2'h0})
         frame(OP_EN, 8);
         frame({8'h02, ROWS[k].addr, ROWS[k].dat, 32'h0}, 32);
         waitWrite(ROWS[k].dat == ROWS[k].want);
         frame({8'h03, ROWS[k].addr, 40'h0}, 32);
         `CHK(i_mst.rxBuf[3], ROWS[k].want)
         `CHK(soOe, 1'b0)
      end
      frame(OP_EN, 8);
      frame({8'h01, 56'h0}, 16);
      waitWrite(1'b1);
      // no enable latch: write refused
      frame({8'h02, 16'h0100, 8'h5A, 32'h0}, 32);
      waitWrite(1'b0);
      // partial page that wraps, status reads all ones while busy
      frame(OP_EN, 8);
      frame({8'h02, 16'h007E, 32'h11223344, 8'h0}, 56);
      frame(OP_RS, 16);
      `CHK(i_mst.rxBuf[1], 8'hFF)
      waitWrite(1'b1);
      frame({8'h03, 16'h007E, 40'h0}, 40);
      `CHK({i_mst.rxBuf[3], i_mst.rxBuf[4]}, 16'h1122)
      frame({8'h03, 16'h0040, 40'h0}, 40);
      `CHK({i_mst.rxBuf[3], i_mst.rxBuf[4]}, 16'h3344)
      // select rises mid-byte: write dropped
      frame(OP_EN, 8);
      frame({8'h02, 16'h0200, 8'h66, 32'h0}, 29);
      waitWrite(1'b0);
      // mode 3 read paused in the address
      i_mst.txBuf[0] = 8'h03;
      i_mst.txBuf[1] = 8'h00;
      i_mst.txBuf[2] = 8'h7E;
      i_mst.xfer(32, 1'b1, 12);
      `CHK(i_mst.rxBuf[3], 8'h11)
      // id page: write, lock, refused rewrite
      frame(OP_EN, 8);
      frame({8'h82, 16'h0005, 8'hC8, 32'h0}, 32);
      waitWrite(1'b1);
      frame(OP_EN, 8);
      frame({8'h87, 56'h0}, 8);
      repeat (WR_CYC + 40) @(negedge clk);
      frame(OP_EN, 8);
      frame({8'h82, 16'h0005, 8'h37, 32'h0}, 32);
      waitWrite(1'b0);
      frame({8'h83, 16'h0005, 40'h0}, 32);
      `CHK(i_mst.rxBuf[3], 8'hC8)
      complete_run();
   end
endmodule
`default_nettype wire
